// ---- core/periodic_and_update_interrupts.sv ----
// Fixed-cycle countdown timer and time update interrupt sources on a shared pin
// Notes on behaviour
// - Countdown event sets the timer flag
// - Timer flag holds until host writes zero
// - Writing one to timer flag does nothing
// - Clearing timer flag leaves interrupt pin low
// - Timer event pulls pin only when enabled
// - Disabling timer interrupt releases its low
// - Timer low releases itself within 7.8 ms
// - Other sources may hold pin while disabled
// - Interval is source period times preset
// - First interval short by up to one period
// - Two select bits pick countdown source clock
// - Countdown starts at serial clock rise after enable
// - Update event on second or minute boundary
// - Update event sets flag until host clears
// - Update event pulls pin only when enabled
// - Update low auto-releases after fixed time
// - Clearing update flag leaves pin low
// - Disabling update interrupt releases its low immediately
// - Every later update event pulls pin again
// - Select zero seconds, one minutes
// - Run rising arms; the next serial clock rise loads the preset
// - Event on count one to zero, reload
`timescale 1ns/1ns
`include "irq_cfg.svh"
module periodic_and_update_interrupts #(
	parameter int FAST_DIV = `FAST_DIV,
	parameter int REL_FAST = `IRQ_AUTO_RELEASE_TIME_FAST_CYC,
	parameter int REL_SLOW = `IRQ_AUTO_RELEASE_TIME_SLOW_CYC,
	parameter int REL_UPD = `IRQ_AUTO_RELEASE_TIME_UPD_CYC
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic scl_i,
	input wire logic timer_run_i,
	input wire logic [`PRESET_W-1:0] timer_preset_i,
	input wire logic timer_source_select_hi_i,
	input wire logic timer_source_select_lo_i,
	input wire logic timer_irq_enable_i,
	input wire logic update_irq_enable_i,
	input wire logic update_period_select_i,
	input wire logic flag_wr_i,
	input wire irq_pkg::flag_bits_t flag_wdata_i,
	output logic timer_event_flag_o,
	output logic update_event_flag_o,
	output logic irq_out_n_o,
	output logic irq_out_n_oe_o
);
	irq_pkg::src_ticks_t ticks;
	irq_pkg::src_sel_t src_sel;
	logic scl_rise;
	logic src_tick;
	logic tim_evt;
	logic upd_evt;
	logic [`REL_W-1:0] tim_rel_cyc;

	irq_pkg::tmr_state_t state_ff;
	irq_pkg::tmr_state_t nxt_state;
	logic run_q_ff;
	logic [`PRESET_W-1:0] cnt_ff;
	logic [`PRESET_W-1:0] nxt_cnt;

	logic tim_flag_ff;
	logic upd_flag_ff;
	logic nxt_tim_flag;
	logic nxt_upd_flag;

	logic tim_low_ff;
	logic upd_low_ff;
	logic [`REL_W-1:0] tim_rel_ff;
	logic [`REL_W-1:0] upd_rel_ff;
	logic nxt_tim_low;
	logic nxt_upd_low;
	logic [`REL_W-1:0] nxt_tim_rel;
	logic [`REL_W-1:0] nxt_upd_rel;
	logic oe_ff;

	tick_gen #(
		.FAST_DIV(FAST_DIV)
	) u_tick (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.ticks_o(ticks)
	);

	scl_sync u_scl (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.scl_i(scl_i),
		.rise_o(scl_rise)
	);

	assign src_sel = irq_pkg::src_sel_t'({timer_source_select_hi_i, timer_source_select_lo_i});

	always_comb begin
		case (src_sel)
			irq_pkg::SRC_4096: src_tick = ticks.t4096;
			irq_pkg::SRC_64: src_tick = ticks.t64;
			irq_pkg::SRC_SEC: src_tick = ticks.sec;
			irq_pkg::SRC_MIN: src_tick = ticks.min;
			default: src_tick = 1'b0;
		endcase
	end

	// Preset 0 never reaches the 1 to 0 step, so it yields no event
	assign tim_evt = (state_ff == irq_pkg::TMR_RUN) && src_tick
		&& (cnt_ff == `PRESET_W'(1));
	assign upd_evt = update_period_select_i ? ticks.min : ticks.sec;
	assign tim_rel_cyc = (src_sel == irq_pkg::SRC_4096) ? `REL_W'(REL_FAST) : `REL_W'(REL_SLOW);

	// Start is not aligned to the source tick, so the first interval runs short
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		case (state_ff)
			irq_pkg::TMR_IDLE: begin
				if (timer_run_i && !run_q_ff) begin
					nxt_state = irq_pkg::TMR_ARMED;
				end
			end
			irq_pkg::TMR_ARMED: begin
				if (scl_rise) begin
					nxt_state = irq_pkg::TMR_RUN;
					nxt_cnt = timer_preset_i;
				end
			end
			irq_pkg::TMR_RUN: begin
				if (tim_evt) begin
					nxt_cnt = timer_preset_i;
				end else if (src_tick && cnt_ff != '0) begin
					nxt_cnt = cnt_ff - `PRESET_W'(1);
				end
			end
			default: nxt_state = irq_pkg::TMR_IDLE;
		endcase
		if (!timer_run_i) begin
			nxt_state = irq_pkg::TMR_IDLE;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			state_ff <= irq_pkg::TMR_IDLE;
			run_q_ff <= 1'b0;
			cnt_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			run_q_ff <= timer_run_i;
			cnt_ff <= nxt_cnt;
		end
	end

	// An event in the clearing cycle wins over the clear
	always_comb begin
		nxt_tim_flag = tim_evt
			| (tim_flag_ff & ~(flag_wr_i & ~flag_wdata_i.timer));
		nxt_upd_flag = upd_evt
			| (upd_flag_ff & ~(flag_wr_i & ~flag_wdata_i.update));
	end

	// Pin requests ignore the flags entirely
	always_comb begin
		nxt_tim_low = tim_low_ff;
		nxt_tim_rel = tim_rel_ff;
		if (!timer_irq_enable_i || !timer_run_i) begin
			nxt_tim_low = 1'b0;
			nxt_tim_rel = '0;
		end else if (tim_evt) begin
			nxt_tim_low = 1'b1;
			nxt_tim_rel = tim_rel_cyc;
		end else if (tim_low_ff) begin
			nxt_tim_rel = tim_rel_ff - `REL_W'(1);
			nxt_tim_low = (tim_rel_ff != `REL_W'(1));
		end
		nxt_upd_low = upd_low_ff;
		nxt_upd_rel = upd_rel_ff;
		if (!update_irq_enable_i) begin
			nxt_upd_low = 1'b0;
			nxt_upd_rel = '0;
		end else if (upd_evt) begin
			nxt_upd_low = 1'b1;
			nxt_upd_rel = `REL_W'(REL_UPD);
		end else if (upd_low_ff) begin
			nxt_upd_rel = upd_rel_ff - `REL_W'(1);
			nxt_upd_low = (upd_rel_ff != `REL_W'(1));
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			tim_flag_ff <= 1'b0;
			upd_flag_ff <= 1'b0;
			tim_low_ff <= 1'b0;
			upd_low_ff <= 1'b0;
			tim_rel_ff <= '0;
			upd_rel_ff <= '0;
			oe_ff <= 1'b0;
		end else begin
			tim_flag_ff <= nxt_tim_flag;
			upd_flag_ff <= nxt_upd_flag;
			tim_low_ff <= nxt_tim_low;
			upd_low_ff <= nxt_upd_low;
			tim_rel_ff <= nxt_tim_rel;
			upd_rel_ff <= nxt_upd_rel;
			oe_ff <= nxt_tim_low | nxt_upd_low;
		end
	end

	assign timer_event_flag_o = tim_flag_ff;
	assign update_event_flag_o = upd_flag_ff;
	assign irq_out_n_o = 1'b0;
	assign irq_out_n_oe_o = oe_ff;

	// Helper: cycles the timer request has stood low
	logic [`REL_W-1:0] tim_age_ff;
	always_ff @(posedge clk_i) begin
		if (!resetn_i || !tim_low_ff) begin
			tim_age_ff <= '0;
		end else begin
			tim_age_ff <= tim_age_ff + `REL_W'(1);
		end
	end

	sequence arm_s;
		state_ff == irq_pkg::TMR_ARMED && scl_rise && timer_run_i;
	endsequence

	sequence run_rise_s;
		!run_q_ff && timer_run_i && state_ff == irq_pkg::TMR_IDLE;
	endsequence

	tim_flag_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		tim_evt |=> timer_event_flag_o)
		else $error("timer flag not set by event");

	tim_flag_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		timer_event_flag_o && !(flag_wr_i && !flag_wdata_i.timer) |=> timer_event_flag_o)
		else $error("timer flag dropped without a zero write");

	tim_flag_write_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		!timer_event_flag_o && !tim_evt |=> !timer_event_flag_o)
		else $error("timer flag set without an event");

	tim_clear_keep_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		tim_low_ff && tim_rel_ff > `REL_W'(1) && timer_irq_enable_i && timer_run_i
		|=> tim_low_ff && irq_out_n_oe_o)
		else $error("timer low ended early");

	tim_no_enable_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		!timer_irq_enable_i |=> !tim_low_ff)
		else $error("timer low while disabled");

	tim_cancel_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		tim_low_ff && $fell(timer_irq_enable_i) |-> !nxt_tim_low)
		else $error("timer low not cancelled");

	tim_release_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		tim_age_ff <= `REL_W'(REL_SLOW))
		else $error("timer low held too long");

	tim_start_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		run_rise_s ##1 (!scl_rise && timer_run_i)[*2] |-> state_ff == irq_pkg::TMR_ARMED)
		else $error("countdown started before serial clock rise");

	tim_load_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		arm_s |=> cnt_ff == $past(timer_preset_i) && state_ff == irq_pkg::TMR_RUN)
		else $error("preset not loaded at start");

	tim_reload_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		tim_evt && timer_run_i |=> cnt_ff == $past(timer_preset_i) && tim_flag_ff)
		else $error("counter not reloaded after event");

	upd_flag_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		upd_evt |=> update_event_flag_o)
		else $error("update flag not set");

	upd_cancel_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		!update_irq_enable_i |=> !upd_low_ff)
		else $error("update low not released");

	upd_rearm_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		upd_evt && update_irq_enable_i |=> upd_low_ff ##1 irq_out_n_oe_o)
		else $error("update event did not pull pin");

	pin_wired_or_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		irq_out_n_oe_o == (tim_low_ff | upd_low_ff))
		else $error("pin enable not the or of sources");
endmodule

// ---- core/irq_cfg.svh ----
// Constants for the periodic and update interrupt block
`ifndef IRQ_CFG_SVH
`define IRQ_CFG_SVH

`define CLK_PERIOD_NS 100
`define CLK_HZ 10000000
`define SRC_FAST_HZ 4096
`define FAST_DIV (`CLK_HZ / `SRC_FAST_HZ)
`define SLOW_DIV 64
`define SEC_DIV 64
`define MIN_DIV 60

`define IRQ_AUTO_RELEASE_TIME_FAST_NS 122000
`define IRQ_AUTO_RELEASE_TIME_SLOW_NS 7800000
`define IRQ_AUTO_RELEASE_TIME_UPD_NS 7182500
`define IRQ_AUTO_RELEASE_TIME_FAST_CYC (`IRQ_AUTO_RELEASE_TIME_FAST_NS / `CLK_PERIOD_NS)
`define IRQ_AUTO_RELEASE_TIME_SLOW_CYC (`IRQ_AUTO_RELEASE_TIME_SLOW_NS / `CLK_PERIOD_NS)
`define IRQ_AUTO_RELEASE_TIME_UPD_CYC (`IRQ_AUTO_RELEASE_TIME_UPD_NS / `CLK_PERIOD_NS)

`define PRESET_W 12
`define REL_W 17
`define DIV_W 16

`endif

// ---- core/irq_pkg.sv ----
// Types shared by the periodic and update interrupt block
package irq_pkg;

	typedef struct packed {
		logic t4096;
		logic t64;
		logic sec;
		logic min;
	} src_ticks_t;

	typedef struct packed {
		logic timer;
		logic update;
	} flag_bits_t;

	typedef enum logic [1:0] {
		SRC_4096 = 2'b00,
		SRC_64 = 2'b01,
		SRC_SEC = 2'b10,
		SRC_MIN = 2'b11
	} src_sel_t;

	typedef enum logic [1:0] {
		TMR_IDLE = 2'b00,
		TMR_ARMED = 2'b01,
		TMR_RUN = 2'b10
	} tmr_state_t;

endpackage

// ---- core/scl_sync.sv ----
// Two-flop synchroniser and rising-edge finder for the serial clock pin
`timescale 1ns/1ns
module scl_sync (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic scl_i,
	output logic rise_o
);
	logic meta_ff;
	logic sync_ff;
	logic prev_ff;
	logic nxt_prev;

	always_comb begin
		nxt_prev = sync_ff;
	end

	always_ff @(posedge clk_i) begin
		// Reset to the idle-high bus level, so release shows no false rise
		if (!resetn_i) begin
			meta_ff <= 1'b1;
			sync_ff <= 1'b1;
			prev_ff <= 1'b1;
		end else begin
			meta_ff <= scl_i;
			sync_ff <= meta_ff;
			prev_ff <= nxt_prev;
		end
	end

	assign rise_o = sync_ff & ~prev_ff;
endmodule

// ---- core/tick_gen.sv ----
// Oscillator divider giving 4096 Hz, 64 Hz, second and minute tick pulses
`timescale 1ns/1ns
`include "irq_cfg.svh"
module tick_gen #(
	parameter int FAST_DIV = `FAST_DIV
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	output irq_pkg::src_ticks_t ticks_o
);
	logic [`DIV_W-1:0] div_ff;
	logic [5:0] c64_ff;
	logic [5:0] csec_ff;
	logic [5:0] cmin_ff;
	irq_pkg::src_ticks_t tick_ff;
	logic [`DIV_W-1:0] nxt_div;
	logic [5:0] nxt_c64;
	logic [5:0] nxt_csec;
	logic [5:0] nxt_cmin;
	irq_pkg::src_ticks_t nxt_tick;

	// Each slower tick lands in the same cycle as the faster one that completes it
	always_comb begin
		nxt_div = div_ff + `DIV_W'(1);
		nxt_c64 = c64_ff;
		nxt_csec = csec_ff;
		nxt_cmin = cmin_ff;
		nxt_tick = '0;
		if (div_ff == `DIV_W'(FAST_DIV - 1)) begin
			nxt_div = '0;
			nxt_tick.t4096 = 1'b1;
			nxt_c64 = c64_ff + 6'h01;
			if (c64_ff == 6'(`SLOW_DIV - 1)) begin
				nxt_c64 = '0;
				nxt_tick.t64 = 1'b1;
				nxt_csec = csec_ff + 6'h01;
				if (csec_ff == 6'(`SEC_DIV - 1)) begin
					nxt_csec = '0;
					nxt_tick.sec = 1'b1;
					nxt_cmin = cmin_ff + 6'h01;
					if (cmin_ff == 6'(`MIN_DIV - 1)) begin
						nxt_cmin = '0;
						nxt_tick.min = 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			div_ff <= '0;
			c64_ff <= '0;
			csec_ff <= '0;
			cmin_ff <= '0;
			tick_ff <= '0;
		end else begin
			div_ff <= nxt_div;
			c64_ff <= nxt_c64;
			csec_ff <= nxt_csec;
			cmin_ff <= nxt_cmin;
			tick_ff <= nxt_tick;
		end
	end

	assign ticks_o = tick_ff;
endmodule

// ---- test/irq_host_model.sv ----
// Host side model: serial clock frames and the timer run bit
`timescale 1ns/1ns
module irq_host_model (
	input wire logic clk_i,
	output logic scl_o,
	output logic timer_run_o
);
	time bit0_time;
	initial begin
		scl_o = 1'b1;
		timer_run_o = 1'b0;
		bit0_time = 0;
	end
	// Data byte then acknowledge; clock idles high between frames
	task automatic set_run(input logic v);
		#37;
		for (int i = 7; i >= -1; i--) begin
			#400 scl_o = 1'b0;
			if (i == 0) begin
				@(posedge clk_i);
				timer_run_o <= v;
				#37;
			end
			#400 scl_o = 1'b1;
			if (i == 0) begin
				bit0_time = $time;
			end
		end
		@(posedge clk_i);
	endtask
endmodule

// ---- test/periodic_and_update_interrupts_tb.sv ----
// Self-checking bench for the periodic and update interrupt block
`timescale 1ns/1ns
module periodic_and_update_interrupts_tb;
	localparam int FDIV = 4;
	localparam int RFAST = 20;
	localparam int RSLOW = 30;
	localparam int RUPD = 25;
	localparam int SEC = FDIV * 64 * 64;
	localparam int PRE[3] = '{8, 2, 1};
	localparam int PER[3] = '{FDIV, FDIV * 64, SEC};
	localparam int REL[3] = '{RFAST, RSLOW, RSLOW};
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic scl;
	logic run;
	logic [11:0] preset = 12'h000;
	logic [1:0] sel = 2'h0;
	logic timer_irq_enable = 1'b0;
	logic update_irq_enable = 1'b0;
	logic update_period_select = 1'b0;
	logic flag_wr = 1'b0;
	irq_pkg::flag_bits_t wdata = 2'h3;
	logic tflag, uflag, irq_n, oe;
	int error_cnt = 0;
	int comparisons = 0;
	int cyc = 0;
	int r, f, t;

	always #50 clk_i = ~clk_i;
	always @(posedge clk_i) cyc <= cyc + 1;

	irq_host_model host_u (.clk_i(clk_i), .scl_o(scl), .timer_run_o(run));
	periodic_and_update_interrupts #(.FAST_DIV(FDIV), .REL_FAST(RFAST), .REL_SLOW(RSLOW),
		.REL_UPD(RUPD)) dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .scl_i(scl),
		.timer_run_i(run), .timer_preset_i(preset), .timer_source_select_hi_i(sel[1]),
		.timer_source_select_lo_i(sel[0]), .timer_irq_enable_i(timer_irq_enable),
		.update_irq_enable_i(update_irq_enable), .update_period_select_i(update_period_select), .flag_wr_i(flag_wr),
		.flag_wdata_i(wdata), .timer_event_flag_o(tflag), .update_event_flag_o(uflag),
		.irq_out_n_o(irq_n), .irq_out_n_oe_o(oe));

	task automatic end_sim();
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check_bit(input string name, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %b seen %b", name, exp, got);
		end
	endtask

	task automatic check_cnt(input string name, input int lo, input int hi, input int got);
		comparisons++;
		if (got < lo || got > hi) begin
			error_cnt++;
			$display("unexpected %s: expected %0d..%0d seen %0d", name, lo, hi, got);
		end
	endtask

	task automatic write_flags(input logic tv, input logic uv);
		@(posedge clk_i);
		flag_wr <= 1'b1;
		wdata <= {tv, uv};
		@(posedge clk_i);
		flag_wr <= 1'b0;
		@(posedge clk_i);
	endtask

	// Bounded wait, so a stuck pin cannot hang the run
	task automatic wait_oe(input logic v, input int limit, output int at);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (oe !== v && n < limit);
		check_bit("oe wait", v, oe);
		at = cyc;
	endtask

	initial begin
		#(100 * 100000);
		error_cnt++;
		$display("unexpected watchdog: expected end seen timeout");
		end_sim();
	end

	initial begin
		repeat (20) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
		check_bit("pin data", 1'b0, irq_n);
		check_bit("reset oe", 1'b0, oe);
		update_period_select <= ~update_period_select;
		for (int k = 0; k < 3; k++) begin
			sel <= 2'(k);
			preset <= 12'(PRE[k]);
			timer_irq_enable <= 1'b1;
			write_flags(1'b0, 1'b0);
			host_u.set_run(1'b1);
			wait_oe(1'b1, 20000, r);
			t = int'(($time - host_u.bit0_time) / 100);
			check_cnt("first", (PRE[k] - 1) * PER[k], PRE[k] * PER[k] + 5, t);
			check_bit("timer flag", 1'b1, tflag);
			if (k == 0) begin
				write_flags(1'b1, 1'b1);
				check_bit("timer flag kept", 1'b1, tflag);
				write_flags(1'b0, 1'b1);
				check_bit("timer flag clear", 1'b0, tflag);
				check_bit("oe after clear", 1'b1, oe);
			end
			wait_oe(1'b0, 100, f);
			check_cnt("release", REL[k], REL[k], f - r);
			wait_oe(1'b1, 20000, t);
			check_cnt("period", PRE[k] * PER[k], PRE[k] * PER[k], t - r);
			timer_irq_enable <= 1'b0;
			repeat (2) @(posedge clk_i);
			check_bit("oe disabled", 1'b0, oe);
			host_u.set_run(1'b0);
		end
		check_bit("update flag minute select", 1'b0, uflag);
		update_period_select <= ~update_period_select;
		sel <= 2'h0;
		preset <= 12'h002;
		write_flags(1'b0, 1'b0);
		host_u.set_run(1'b1);
		t = 0;
		repeat (60) begin
			@(posedge clk_i);
			t += int'(oe !== 1'b0);
		end
		check_cnt("oe timer off", 0, 0, t);
		check_bit("flag timer off", 1'b1, tflag);
		host_u.set_run(1'b0);
		preset <= 12'h000;
		write_flags(1'b0, 1'b0);
		host_u.set_run(1'b1);
		repeat (60) @(posedge clk_i);
		check_bit("flag preset zero", 1'b0, tflag);
		host_u.set_run(1'b0);
		sel <= 2'h3;
		preset <= 12'h001;
		host_u.set_run(1'b1);
		update_irq_enable <= 1'b1;
		write_flags(1'b0, 1'b0);
		wait_oe(1'b1, SEC + 100, r);
		check_bit("update flag", 1'b1, uflag);
		write_flags(1'b1, 1'b0);
		check_bit("update flag clear", 1'b0, uflag);
		check_bit("oe update clear", 1'b1, oe);
		wait_oe(1'b0, 100, f);
		check_cnt("update release", RUPD, RUPD, f - r);
		wait_oe(1'b1, SEC + 100, t);
		check_cnt("update period", SEC, SEC, t - r);
		update_irq_enable <= 1'b0;
		repeat (2) @(posedge clk_i);
		check_bit("oe update off", 1'b0, oe);
		check_bit("flag minute source", 1'b0, tflag);
		end_sim();
	end
endmodule
